// ---- src/extbus_iface.sv ----
// External memory bus interface: multiplexed address/data cycle engine
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Bus enabled only when both enables zero
// - All addresses shown on ports when enabled
// - Internal data phase drives address/data zero
// - Program fetch strobes with program-store strobe
// - Data read/write use read/write strobes
// - Program fetch places full 16-bit address
// - Pointer form 16-bit, register form 8-bit
// - Both enable bits zero dedicate high port and strobes
// - Page byte held high for 8-bit access
// - Low address then data on one port
// - Bus pins actively driven push-pull
// - Low address valid at latch strobe fall
// - Write data brackets the write strobe
// - Read byte sampled before strobe release
// - Config bits writable only in programming mode
// - Default configuration means general-purpose I/O
// - Access in I/O mode leaves ports unchanged
// - Strap low at reset forces external fetches
// - Fetch beyond internal range goes external only while the bus is enabled (both enables zero) or the strap was low at reset
// - Fetch drives program counter high byte
module extbus_iface
    import extbus_pkg::*;
#(
    parameter logic [15:0] INT_PROG_TOP = EXTBUS_INT_PROG_TOP
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic progMode,
    input wire logic cfgWrEn,
    input wire logic [7:0] cfgWrData,
    input wire logic externalAccessStrapN,
    input wire logic sfrWrEn,
    input wire logic sfrRdEn,
    input wire logic [7:0] sfrAddr,
    input wire logic [7:0] sfrWrData,
    input wire logic [7:0] port0Latch,
    input wire logic [7:0] port2Latch,
    input wire logic [1:0] port3StrobeLatch,
    input wire logic reqValid,
    input wire logic [1:0] reqKind,
    input wire logic reqShortAddr,
    input wire logic reqInternal,
    input wire logic [15:0] reqAddr,
    input wire logic [7:0] reqWrData,
    input wire logic [7:0] adIn,
    output logic [7:0] sfrRdData,
    output logic reqReady,
    output logic respValid,
    output logic [7:0] respData,
    output logic fetchExternal,
    output logic [7:0] adOut,
    output logic adOe,
    output logic [7:0] highAddrOut,
    output logic addrLatchStrobe,
    output logic programStoreStrobeN,
    output logic readStrobeN,
    output logic writeStrobeN,
    output logic busEnabled
);
    logic [7:0] cfgByte_q;
    logic [7:0] pageByte_q;
    logic strapSeen_q;
    logic strapLow_q;
    extbus_state_t state_q;
    logic [1:0] cnt_q;
    extbus_kind_t kind_q;
    logic internal_q;
    logic [15:0] addr_q;
    logic [7:0] wrData_q;
    logic cfgBusOn;
    logic [1:0] strobeRun_q;

    // Neither enable bit alone claims any pins; only both zero give the full bus
    assign cfgBusOn = !cfgByte_q[EXTBUS_CFG_GP0_BIT] && !cfgByte_q[EXTBUS_CFG_GP23_BIT];

    // Nonvolatile config holds ones by default; writes only land in programming mode
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cfgByte_q <= EXTBUS_CFG_RESET;
        end else if (cfgWrEn && progMode) begin
            cfgByte_q <= cfgWrData;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pageByte_q <= EXTBUS_PAGE_RESET;
        end else if (sfrWrEn && sfrAddr == EXTBUS_PAGE_OFFSET) begin
            pageByte_q <= sfrWrData;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sfrRdData <= EXTBUS_ZERO_BYTE;
        end else if (sfrRdEn && sfrAddr == EXTBUS_PAGE_OFFSET) begin
            sfrRdData <= pageByte_q;
        end else begin
            sfrRdData <= EXTBUS_ZERO_BYTE;
        end
    end

    // Strap is caught on the first edge after release, never by the async reset
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            strapSeen_q <= 1'b0;
            strapLow_q <= 1'b0;
        end else if (!strapSeen_q) begin
            strapSeen_q <= 1'b1;
            strapLow_q <= !externalAccessStrapN;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fetchExternal <= 1'b0;
            busEnabled <= 1'b0;
        end else begin
            fetchExternal <= strapLow_q || (cfgBusOn && reqAddr > INT_PROG_TOP);
            busEnabled <= cfgBusOn;
        end
    end

    // Cycle engine: address phase, setup, strobe, hold
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= EXTBUS_IDLE;
            cnt_q <= 2'h0;
            kind_q <= EXTBUS_FETCH;
            internal_q <= 1'b0;
            addr_q <= 16'h0000;
            wrData_q <= EXTBUS_ZERO_BYTE;
        end else begin
            case (state_q)
                EXTBUS_IDLE: begin
                    // In I/O mode requests are swallowed and the pins never move
                    if (reqValid && cfgBusOn) begin
                        state_q <= EXTBUS_ADDR;
                        cnt_q <= EXTBUS_ALE_CYCLES - 2'h1;
                        kind_q <= extbus_kind_t'(reqKind);
                        internal_q <= reqInternal;
                        // Register form takes its high byte from the page register
                        addr_q <= (reqShortAddr && reqKind != EXTBUS_FETCH) ?
                            {pageByte_q, reqAddr[7:0]} : reqAddr;
                        wrData_q <= reqWrData;
                    end
                end
                EXTBUS_ADDR: begin
                    if (cnt_q == 2'h0) begin
                        state_q <= EXTBUS_SETUP;
                        cnt_q <= EXTBUS_SETUP_CYCLES - 2'h1;
                    end else begin
                        cnt_q <= cnt_q - 2'h1;
                    end
                end
                EXTBUS_SETUP: begin
                    if (cnt_q == 2'h0) begin
                        state_q <= EXTBUS_STROBE;
                        cnt_q <= EXTBUS_STROBE_CYCLES - 2'h1;
                    end else begin
                        cnt_q <= cnt_q - 2'h1;
                    end
                end
                EXTBUS_STROBE: begin
                    if (cnt_q == 2'h0) begin
                        state_q <= EXTBUS_HOLD;
                        cnt_q <= EXTBUS_HOLD_CYCLES - 2'h1;
                    end else begin
                        cnt_q <= cnt_q - 2'h1;
                    end
                end
                EXTBUS_HOLD: begin
                    if (cnt_q == 2'h0) begin
                        state_q <= EXTBUS_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 2'h1;
                    end
                end
                default: begin
                    state_q <= EXTBUS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reqReady <= 1'b0;
        end else begin
            reqReady <= (state_q == EXTBUS_IDLE) && !(reqValid && cfgBusOn);
        end
    end

    // Read data is taken on the last strobe cycle, before the strobe rises
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            respData <= EXTBUS_ZERO_BYTE;
        end else if (state_q == EXTBUS_STROBE && cnt_q == 2'h0 && kind_q != EXTBUS_WRITE) begin
            respData <= adIn;
        end
    end

    // Completion is reported only once the strobe is back high
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            respValid <= 1'b0;
        end else begin
            respValid <= (state_q == EXTBUS_HOLD && cnt_q == 2'h0);
        end
    end

    // Length of the current strobe pulse, saturating, for the width check
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            strobeRun_q <= 2'h0;
        end else if (!programStoreStrobeN || !readStrobeN || !writeStrobeN) begin
            strobeRun_q <= (strobeRun_q == 2'h3) ? strobeRun_q : strobeRun_q + 2'h1;
        end else begin
            strobeRun_q <= 2'h0;
        end
    end

    // Pin drivers, all registered; push-pull while the bus owns the port
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            adOut <= EXTBUS_ONES_BYTE;
            adOe <= 1'b0;
            highAddrOut <= EXTBUS_ONES_BYTE;
            addrLatchStrobe <= 1'b0;
            programStoreStrobeN <= 1'b1;
            readStrobeN <= 1'b1;
            writeStrobeN <= 1'b1;
        end else begin
            adOe <= cfgBusOn && !(state_q == EXTBUS_SETUP && kind_q != EXTBUS_WRITE && !internal_q) &&
                !(state_q == EXTBUS_STROBE && kind_q != EXTBUS_WRITE && !internal_q);
            // The address must already stand while the latch strobe is high
            highAddrOut <= !cfgBusOn ? EXTBUS_ONES_BYTE :
                (state_q != EXTBUS_IDLE) ? addr_q[15:8] :
                !reqValid ? port2Latch :
                (reqShortAddr && reqKind != EXTBUS_FETCH) ? pageByte_q :
                reqAddr[15:8];
            addrLatchStrobe <= (state_q == EXTBUS_IDLE && reqValid && cfgBusOn) ||
                (state_q == EXTBUS_ADDR && cnt_q != 2'h0);
            case (state_q)
                EXTBUS_IDLE: begin
                    adOut <= !cfgBusOn ? EXTBUS_ONES_BYTE :
                        reqValid ? reqAddr[7:0] : port0Latch;
                end
                EXTBUS_ADDR: begin
                    adOut <= addr_q[7:0];
                end
                default: begin
                    adOut <= internal_q ? EXTBUS_ZERO_BYTE : wrData_q;
                end
            endcase
            // Strobes fall a cycle after the data phase opens, so write data leads them
            // and stays through the hold cycle after they rise
            programStoreStrobeN <= state_q != EXTBUS_STROBE ||
                kind_q != EXTBUS_FETCH || internal_q;
            readStrobeN <= state_q != EXTBUS_STROBE ||
                kind_q != EXTBUS_READ || internal_q;
            writeStrobeN <= state_q != EXTBUS_STROBE ||
                kind_q != EXTBUS_WRITE || internal_q;
        end
    end

    a_cfg_locked: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (cfgWrEn && !progMode) |=> $stable(cfgByte_q)) else $error("config changed outside programming mode");
    a_io_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !cfgBusOn |=> (readStrobeN && writeStrobeN && programStoreStrobeN && !addrLatchStrobe))
        else $error("strobe moved in I/O mode");
    a_fetch_program_store_strobe_n: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !programStoreStrobeN |-> (readStrobeN && writeStrobeN)) else $error("two strobes active");
    a_addr_latch: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $fell(addrLatchStrobe) |-> adOut == $past(addr_q[7:0])) else $error("address not valid at latch fall");
    a_internal_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_q == EXTBUS_STROBE && internal_q) |=> adOut == EXTBUS_ZERO_BYTE) else $error("internal data exposed");
    a_wr_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(writeStrobeN) |-> (adOut == $past(adOut) && adOe)) else $error("write data moved at strobe release");
    a_page_high: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_q == EXTBUS_IDLE && reqValid && cfgBusOn && reqShortAddr && reqKind == EXTBUS_READ) |-> ##2
        highAddrOut == $past(pageByte_q, 2)) else $error("page byte not on high port");
    a_strobe_len: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $fell(readStrobeN) |-> !readStrobeN [*2] ##1 readStrobeN) else $error("read strobe length wrong");
    a_default_io: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(strapSeen_q) |-> !busEnabled && !cfgBusOn) else $error("bus enabled by default");

    // Pin and strobe relations across the whole cycle
    a_bus_mirror: assert property (@(posedge clk_sys) disable iff (!rst_n)
        busEnabled == $past(cfgBusOn)) else $error("bus enable flag out of step");
    a_rd_exclusive: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !readStrobeN |-> (writeStrobeN && programStoreStrobeN)) else $error("read strobe with another");
    a_port_release: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (!readStrobeN || !programStoreStrobeN) |-> !adOe) else $error("port driven during read");
    a_wr_lead: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $fell(writeStrobeN) |-> (adOe && adOut == $past(adOut))) else $error("write data late");
    a_io_pins: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !cfgBusOn |=> (!adOe && adOut == EXTBUS_ONES_BYTE && highAddrOut == EXTBUS_ONES_BYTE))
        else $error("port pins moved in I/O mode");
    a_fetch_full: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_q == EXTBUS_IDLE && reqValid && cfgBusOn && reqKind == EXTBUS_FETCH) |=>
        addr_q == $past(reqAddr)) else $error("fetch address not full width");
    a_strap_fetch: assert property (@(posedge clk_sys) disable iff (!rst_n)
        strapLow_q |=> fetchExternal) else $error("strap did not force external fetch");
    a_high_fetch: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (cfgBusOn && reqAddr > INT_PROG_TOP) |=> fetchExternal) else $error("high fetch kept internal");
    a_resp_time: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_q == EXTBUS_IDLE && reqValid && cfgBusOn) |-> ##7 respValid)
        else $error("cycle did not complete in time");
    a_resp_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
        respValid |=> !respValid) else $error("completion longer than one cycle");
    a_strobe_width: assert property (@(posedge clk_sys) disable iff (!rst_n)
        strobeRun_q <= EXTBUS_STROBE_CYCLES) else $error("strobe held too long");

    c_fetch: cover property (@(posedge clk_sys) disable iff (!rst_n) $fell(programStoreStrobeN));
    c_internal: cover property (@(posedge clk_sys) disable iff (!rst_n) state_q == EXTBUS_STROBE && internal_q);
    c_read: cover property (@(posedge clk_sys) disable iff (!rst_n) $fell(readStrobeN));
    c_write: cover property (@(posedge clk_sys) disable iff (!rst_n) $fell(writeStrobeN));
endmodule // extbus_iface

`default_nettype wire

// ---- src/extbus_pkg.sv ----
// Package for the external memory bus interface: register offsets, config fields, cycle timing
package extbus_pkg;
    localparam logic [7:0] EXTBUS_PAGE_OFFSET = 8'h92;
    localparam logic [7:0] EXTBUS_PAGE_RESET = 8'h00;
    localparam logic [7:0] EXTBUS_CFG_RESET = 8'hFF;
    localparam int EXTBUS_CFG_GP0_BIT = 1;
    localparam int EXTBUS_CFG_GP23_BIT = 0;
    localparam logic [7:0] EXTBUS_ZERO_BYTE = 8'h00;
    localparam logic [7:0] EXTBUS_ONES_BYTE = 8'hFF;
    // Phase lengths in clk_sys cycles
    localparam logic [1:0] EXTBUS_ALE_CYCLES = 2'h2;
    localparam logic [1:0] EXTBUS_SETUP_CYCLES = 2'h1;
    localparam logic [1:0] EXTBUS_STROBE_CYCLES = 2'h2;
    localparam logic [1:0] EXTBUS_HOLD_CYCLES = 2'h1;
    localparam logic [15:0] EXTBUS_INT_PROG_TOP = 16'h7FFF;

    typedef enum logic [1:0] {
        EXTBUS_FETCH,
        EXTBUS_READ,
        EXTBUS_WRITE
    } extbus_kind_t;

    typedef enum {
        EXTBUS_IDLE,
        EXTBUS_ADDR,
        EXTBUS_SETUP,
        EXTBUS_STROBE,
        EXTBUS_HOLD
    } extbus_state_t;
endpackage

// ---- tb/extbus_iface_tb.sv ----
// Self-checking testbench for the external memory bus interface
`timescale 1ns/1ps
`default_nettype none
module extbus_iface_tb
    import extbus_pkg::*;
;
    logic clk_sys = 1'b0, rst_n = 1'b0, progMode = 1'b0, cfgWrEn = 1'b0, strapN = 1'b1;
    logic sfrWrEn = 1'b0, sfrRdEn = 1'b0, reqValid = 1'b0, reqShortAddr = 1'b0, reqInternal = 1'b0;
    logic [7:0] cfgWrData = 8'hFF, sfrAddr = 8'h00, sfrWrData = 8'h00, reqWrData = 8'h00;
    logic [7:0] port0Latch = 8'hC3, port2Latch = 8'hFF, rd, expHigh, expWr, aleLo;
    logic [1:0] port3StrobeLatch = 2'b11, reqKind = 2'h0;
    logic [15:0] reqAddr = 16'h0000, badCnt;
    logic [11:0] stbCnt;
    logic [7:0] adIn, sfrRdData, respData, adOut, highAddrOut;
    logic reqReady, respValid, fetchExternal, adOe, addrLatchStrobe, programStoreStrobeN;
    logic readStrobeN, writeStrobeN, busEnabled, mon = 1'b0, aleSeen, isInt, prevWr, aleOff;
    int fails = 0, checks = 0;
    always #2.5 clk_sys = ~clk_sys;
    extbus_iface dut (.clk_sys(clk_sys), .rst_n(rst_n), .progMode(progMode), .cfgWrEn(cfgWrEn),
        .cfgWrData(cfgWrData), .externalAccessStrapN(strapN), .sfrWrEn(sfrWrEn), .sfrRdEn(sfrRdEn),
        .sfrAddr(sfrAddr), .sfrWrData(sfrWrData), .port0Latch(port0Latch), .port2Latch(port2Latch),
        .port3StrobeLatch(port3StrobeLatch), .reqValid(reqValid), .reqKind(reqKind),
        .reqShortAddr(reqShortAddr), .reqInternal(reqInternal), .reqAddr(reqAddr), .reqWrData(reqWrData),
        .adIn(adIn), .sfrRdData(sfrRdData), .reqReady(reqReady), .respValid(respValid),
        .respData(respData), .fetchExternal(fetchExternal), .adOut(adOut), .adOe(adOe),
        .highAddrOut(highAddrOut), .addrLatchStrobe(addrLatchStrobe),
        .programStoreStrobeN(programStoreStrobeN), .readStrobeN(readStrobeN),
        .writeStrobeN(writeStrobeN), .busEnabled(busEnabled));
    extbus_mem_model mem (.clk_sys(clk_sys), .adOut(adOut), .adOe(adOe), .highAddrOut(highAddrOut),
        .addrLatchStrobe(addrLatchStrobe), .programStoreStrobeN(programStoreStrobeN),
        .readStrobeN(readStrobeN), .writeStrobeN(writeStrobeN), .adIn(adIn));
    // Pin watcher for one bus cycle, sampled mid-cycle where everything has settled
    always @(negedge clk_sys) begin
        if (mon) begin
            if (addrLatchStrobe === 1'b1) begin
                aleLo = adOut;
                aleSeen = 1'b1;
            end
            stbCnt = stbCnt + {3'h0, ~programStoreStrobeN, 3'h0, ~readStrobeN, 3'h0, ~writeStrobeN};
            if (aleSeen && highAddrOut !== expHigh) badCnt++;
            if (!writeStrobeN && (adOut !== expWr || adOe !== 1'b1)) badCnt++;
            if (prevWr && writeStrobeN === 1'b1 && adOut !== expWr) badCnt++;
            // Internal cycles must show zero on the port from the second cycle after the latch strobe falls
            if (aleOff && isInt && adOut !== 8'h00) badCnt++;
            aleOff = aleSeen && addrLatchStrobe === 1'b0;
            prevWr = (writeStrobeN === 1'b0);
        end
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic reset_dut(input logic strap);
        strapN = strap;
        rst_n = 1'b0;
        repeat (10) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (2) @(negedge clk_sys);
    endtask
    task automatic sfr_access(input logic wr, input logic [7:0] addr, input logic [7:0] wd);
        sfrAddr = addr;
        sfrWrData = wd;
        sfrWrEn = wr;
        sfrRdEn = ~wr;
        @(negedge clk_sys);
        sfrWrEn = 1'b0;
        sfrRdEn = 1'b0;
        rd = sfrRdData;
    endtask
    task automatic cfg_write(input logic [7:0] v);
        cfgWrData = v;
        cfgWrEn = 1'b1;
        @(negedge clk_sys);
        cfgWrEn = 1'b0;
        repeat (2) @(negedge clk_sys);
    endtask
    task automatic do_req(input logic [1:0] kind, input logic shortA, input logic intl, input logic [15:0] addr,
        input logic [7:0] wd, input logic [7:0] expRd, input logic [7:0] expHi, input logic expFx,
        input logic expResp);
        int n;
        logic [15:0] pins;
        n = 0;
        while (reqReady !== 1'b1 && expResp && n < 20) begin
            @(negedge clk_sys);
            n++;
        end
        if (expResp && reqReady !== 1'b1) begin
            check(reqReady, 1'b1);
            give_verdict();
        end
        pins = {adOut, highAddrOut};
        reqKind = kind;
        reqShortAddr = shortA;
        reqInternal = intl;
        reqAddr = addr;
        reqWrData = wd;
        reqValid = 1'b1;
        expHigh = expHi;
        expWr = wd;
        isInt = intl;
        aleSeen = 1'b0;
        aleOff = 1'b0;
        prevWr = 1'b0;
        stbCnt = 12'h000;
        badCnt = 16'h0000;
        mon = 1'b1;
        @(negedge clk_sys);
        reqValid = 1'b0;
        if (kind == EXTBUS_FETCH) check(fetchExternal, expFx);
        n = 1;
        while (respValid !== 1'b1 && n < 12) begin
            @(negedge clk_sys);
            n++;
        end
        mon = 1'b0;
        check(n < 12, expResp);
        if (!expResp) begin
            check({adOut, highAddrOut}, pins);
            check(stbCnt, 12'h000);
        end else if (n >= 12) begin
            give_verdict();
        end else begin
            check(aleLo, addr[7:0]);
            check(stbCnt, intl ? 12'h000 : kind == EXTBUS_FETCH ? 12'h200 :
                kind == EXTBUS_READ ? 12'h020 : 12'h002);
            check(badCnt, 16'h0000);
            if (kind != EXTBUS_WRITE && !intl) check(respData, expRd);
            @(negedge clk_sys);
            check({programStoreStrobeN, readStrobeN, writeStrobeN}, 3'b111);
        end
    endtask
    initial begin
        reset_dut(1'b1);
        check({programStoreStrobeN, readStrobeN, writeStrobeN, addrLatchStrobe, busEnabled}, 5'b11100);
        sfr_access(1'b0, EXTBUS_PAGE_OFFSET, 8'h00);
        check(rd, EXTBUS_PAGE_RESET);
        sfr_access(1'b1, EXTBUS_PAGE_OFFSET, 8'h5A);
        sfr_access(1'b0, EXTBUS_PAGE_OFFSET, 8'h00);
        check(rd, 8'h5A);
        sfr_access(1'b0, 8'h93, 8'h00);
        check(rd, 8'h00);
        $display("test page register done");
        do_req(EXTBUS_FETCH, 1'b0, 1'b0, 16'h8123, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0);
        cfg_write(8'h00);
        check(busEnabled, 1'b0);
        progMode = 1'b1;
        cfg_write(8'hFD);
        check(busEnabled, 1'b0);
        cfg_write(8'hFE);
        check(busEnabled, 1'b0);
        cfg_write(8'hFC);
        check(busEnabled, 1'b1);
        progMode = 1'b0;
        $display("test configuration done");
        do_req(EXTBUS_FETCH, 1'b0, 1'b0, 16'h8123, 8'h00, 8'h23 ^ 8'h81 ^ 8'h3C, 8'h81, 1'b1, 1'b1);
        do_req(EXTBUS_READ, 1'b0, 1'b0, 16'h1234, 8'h00, 8'h12 ^ 8'h34 ^ 8'h3C, 8'h12, 1'b0, 1'b1);
        do_req(EXTBUS_WRITE, 1'b0, 1'b0, 16'h2345, 8'hA7, 8'h00, 8'h23, 1'b0, 1'b1);
        do_req(EXTBUS_READ, 1'b0, 1'b0, 16'h2345, 8'h00, 8'hA7, 8'h23, 1'b0, 1'b1);
        do_req(EXTBUS_READ, 1'b1, 1'b0, 16'h0077, 8'h00, 8'h77 ^ 8'h5A ^ 8'h3C, 8'h5A, 1'b0, 1'b1);
        do_req(EXTBUS_READ, 1'b0, 1'b1, 16'h0100, 8'h00, 8'h00, 8'h01, 1'b0, 1'b1);
        do_req(EXTBUS_FETCH, 1'b0, 1'b1, 16'h0010, 8'h00, 8'h00, 8'h00, 1'b0, 1'b1);
        $display("test bus cycles done");
        reset_dut(1'b0);
        do_req(EXTBUS_FETCH, 1'b0, 1'b0, 16'h0010, 8'h00, 8'h00, 8'h00, 1'b1, 1'b0);
        $display("test strap done");
        give_verdict();
    end
endmodule // extbus_iface_tb
`default_nettype wire

// ---- tb/extbus_mem_model.sv ----
// Behavioural model of the external address latch and the program/data memory
`timescale 1ns/1ps
`default_nettype none
module extbus_mem_model (
    input wire logic clk_sys,
    input wire logic [7:0] adOut,
    input wire logic adOe,
    input wire logic [7:0] highAddrOut,
    input wire logic addrLatchStrobe,
    input wire logic programStoreStrobeN,
    input wire logic readStrobeN,
    input wire logic writeStrobeN,
    output logic [7:0] adIn
);
    logic [7:0] mem [0:65535];
    logic [7:0] latchLo_q;
    logic [7:0] lastOut_q;
    logic driving;
    initial begin
        for (int i = 0; i < 65536; i++) begin
            mem[i] = 8'(i) ^ 8'(i >> 8) ^ 8'h3C;
        end
        latchLo_q = 8'h00;
        lastOut_q = 8'h00;
    end
    // Transparent while the strobe is high, so the byte kept is the one present at its fall
    always @(posedge clk_sys) begin
        if (addrLatchStrobe) begin
            latchLo_q <= adOut;
        end
        if (!writeStrobeN) begin
            mem[{highAddrOut, latchLo_q}] <= adOut;
        end
        if (driving) begin
            lastOut_q <= adIn;
        end
    end
    // Program and data reads share one memory, as with the two read strobes gated together
    assign driving = (!readStrobeN || !programStoreStrobeN) && !adOe;
    // No pull-up on the released bus: show the inverse of the last byte, never a stale copy
    assign adIn = driving ? mem[{highAddrOut, latchLo_q}] : ~lastOut_q;
endmodule // extbus_mem_model
`default_nettype wire
